// ==== core/video_cursor_sound_dma.sv ====
// dma address generator and processor/dma memory arbiter
// assumes one dram word per memAck pulse and processor cycle
// announcements on cpuCycle, all on core_clk; pins are asynchronous
`timescale 1ns/1ps
module video_cursor_sound_dma (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [dma_addr_gen_pkg::CPU_ADDR_W-1:0] cpuAddr,
    input wire logic cpuCycle,
    input wire logic cpuMreq,
    input wire logic cpuSeq,
    input wire logic cpuWrite,
    input wire logic cpuSupervisor,
    input wire logic soundDmaEnable,
    input wire logic refreshReq,
    input wire logic ioCycleWanted,
    input wire logic ioWaiting,
    input wire logic memAck,
    input wire logic vc_dma_req_n,
    input wire logic soundDmaReqN,
    input wire logic cursor_select_n,
    input wire logic flyback_in,
    input wire logic ioClk,
    output logic [dma_addr_gen_pkg::DRAM_ADDR_W-1:0] dramAddr,
    output logic dramStrobe,
    output logic dramSeq,
    output logic refreshActive,
    output logic vc_dma_ack_n,
    output logic soundDmaAckN,
    output logic sound_irq_n,
    output logic cpu_bus_drive_en,
    output logic cpuPhi1Hold,
    output logic io_cycle_req_n
);
    typedef enum logic [1:0] {ST_IDLE, ST_DMA, ST_REFRESH} arb_state_t;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    arb_state_t state;
    dma_addr_gen_pkg::dma_kind_t kind;
    dma_addr_gen_pkg::dma_kind_t next_kind;
    logic [4:0] pinSync;
    logic vcReq;
    logic sndReq;
    logic cursorSel;
    logic flyback;
    logic ioClkLow;
    logic vcReqPrev;
    logic flybackPrev;
    logic cursorPick;
    logic [1:0] wordCnt;
    logic [1:0] seqCount;
    logic dmaPending;
    logic procSeqNext;
    logic startOk;
    logic dmaStart;
    logic refreshStart;
    logic dmaDone;
    logic wordTaken;
    logic ioHold;
    logic regWrite;
    logic [2:0] regSel;
    logic [dma_addr_gen_pkg::PTR_W-1:0] regValue;
    logic initOk;
    logic videoInitDue;
    logic [dma_addr_gen_pkg::PTR_W-1:0] video_frame_init_pointer;
    logic [dma_addr_gen_pkg::PTR_W-1:0] video_buffer_start;
    logic [dma_addr_gen_pkg::PTR_W-1:0] video_buffer_end;
    logic [dma_addr_gen_pkg::PTR_W-1:0] cursor_buffer_init;
    logic [dma_addr_gen_pkg::PTR_W-1:0] videoPtr;
    logic [dma_addr_gen_pkg::PTR_W-1:0] cursorPtr;
    logic [dma_addr_gen_pkg::PTR_W-1:0] soundPtr;
    logic [dma_addr_gen_pkg::PTR_W-1:0] next_ptr;
    logic soundNextValid;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    sync_2ff #(
        .WIDTH(5),
        .RESET_VAL(dma_addr_gen_pkg::PIN_RESET)
    ) u_pin_sync (
        .clk(core_clk),
        .resetn(resetn),
        .asyncIn({ioClk, flyback_in, cursor_select_n, soundDmaReqN,
                  vc_dma_req_n}),
        .syncOut(pinSync)
    );

    // synchronised pin levels
    assign vcReq = ~pinSync[0];
    assign sndReq = ~pinSync[1] & soundDmaEnable;
    assign cursorSel = ~pinSync[2];
    assign flyback = pinSync[3];
    assign ioClkLow = ~pinSync[4];

    // previous levels for edge detection
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vcReqPrev <= 1'b0;
            flybackPrev <= 1'b0;
        end else begin
            vcReqPrev <= vcReq;
            flybackPrev <= flyback;
        end
    end

    // ----------------------------------------------------------------
    // register write decode
    // ----------------------------------------------------------------
    assign regSel =
        cpuAddr[dma_addr_gen_pkg::SEL_HI:dma_addr_gen_pkg::SEL_LO];
    assign regValue =
        cpuAddr[dma_addr_gen_pkg::VAL_HI:dma_addr_gen_pkg::VAL_LO];

    // taken only from an idle arbiter, supervisor mode, matching pattern
    assign regWrite = (state == ST_IDLE) & cpuCycle & cpuMreq & cpuWrite
        & cpuSupervisor
        & (cpuAddr[dma_addr_gen_pkg::MATCH_HI:dma_addr_gen_pkg::MATCH_LO]
           == dma_addr_gen_pkg::MATCH_CODE);

    // video and cursor setup registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            video_frame_init_pointer <= dma_addr_gen_pkg::PTR_RESET;
            video_buffer_start <= dma_addr_gen_pkg::PTR_RESET;
            video_buffer_end <= dma_addr_gen_pkg::PTR_RESET;
            cursor_buffer_init <= dma_addr_gen_pkg::PTR_RESET;
        end else if (regWrite) begin
            unique case (regSel)
                dma_addr_gen_pkg::SEL_VIDEO_INIT: begin
                    video_frame_init_pointer <= regValue;
                end
                dma_addr_gen_pkg::SEL_VIDEO_START: begin
                    video_buffer_start <= regValue;
                end
                dma_addr_gen_pkg::SEL_VIDEO_END: begin
                    video_buffer_end <= regValue;
                end
                dma_addr_gen_pkg::SEL_CURSOR_INIT: begin
                    cursor_buffer_init <= regValue;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sound buffer pointer
    // ----------------------------------------------------------------
    sound_buffer_ctrl u_sound (
        .clk(core_clk),
        .resetn(resetn),
        .wrNextStart(regWrite & (regSel == dma_addr_gen_pkg::SEL_SOUND_START)),
        .wrNextEnd(regWrite & (regSel == dma_addr_gen_pkg::SEL_SOUND_END)),
        .wrSwap(regWrite & (regSel == dma_addr_gen_pkg::SEL_SOUND_SWAP)),
        .wrValue(regValue),
        .advance(dmaDone & (kind == dma_addr_gen_pkg::KIND_SOUND)),
        .soundPtr(soundPtr),
        .nextValid(soundNextValid),
        .sound_irq_n(sound_irq_n)
    );

    // ----------------------------------------------------------------
    // request selection and arbitration terms
    // ----------------------------------------------------------------
    assign dmaPending = vcReq | sndReq;
    assign wordTaken = (state == ST_DMA) & memAck;
    assign dmaDone = wordTaken & (wordCnt == dma_addr_gen_pkg::WORD_LAST);

    // processor keeps the bus for a sequential access below the limit
    assign procSeqNext = cpuCycle & cpuMreq & cpuSeq
        & (seqCount != dma_addr_gen_pkg::MAX_SEQ);

    // a suspended i/o cycle must first be withdrawn
    assign startOk = ioHold
        | (cpuCycle & ~procSeqNext & ~ioWaiting & ~regWrite);
    assign dmaStart = (state == ST_IDLE) & dmaPending & startOk;
    assign refreshStart = (state == ST_IDLE) & ~dmaPending & refreshReq
        & startOk;

    // video/cursor first; select at the request edge, else the latch
    always_comb begin
        next_kind = dma_addr_gen_pkg::KIND_SOUND;
        if (vcReq) begin
            next_kind = (~vcReqPrev ? cursorSel : cursorPick)
                ? dma_addr_gen_pkg::KIND_CURSOR
                : dma_addr_gen_pkg::KIND_VIDEO;
        end
    end

    // select latch: request edge, or penultimate ack of a video or cursor fetch
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cursorPick <= 1'b0;
        end else if (vcReq & ~vcReqPrev) begin
            cursorPick <= cursorSel;
        end else if (wordTaken & (kind != dma_addr_gen_pkg::KIND_SOUND)
                     & (wordCnt == dma_addr_gen_pkg::WORD_PENULT)) begin
            cursorPick <= cursorSel;
        end
    end

    // consecutive processor sequential cycle count
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            seqCount <= 2'h0;
        end else if (state != ST_IDLE || dmaStart || refreshStart) begin
            seqCount <= 2'h0;
        end else if (cpuCycle) begin
            if (cpuMreq & cpuSeq & (seqCount != dma_addr_gen_pkg::MAX_SEQ))
            begin
                seqCount <= seqCount + dma_addr_gen_pkg::WORD_STEP;
            end else begin
                seqCount <= 2'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // memory cycle sequencer
    // ----------------------------------------------------------------
    always_comb begin
        unique case (next_kind)
            dma_addr_gen_pkg::KIND_VIDEO: next_ptr = videoPtr;
            dma_addr_gen_pkg::KIND_CURSOR: next_ptr = cursorPtr;
            default: next_ptr = soundPtr;
        endcase
    end

    // dma: one nonsequential word then three sequential ones; refresh: a single word
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            kind <= dma_addr_gen_pkg::KIND_VIDEO;
            wordCnt <= dma_addr_gen_pkg::WORD_FIRST;
            dramAddr <= '0;
            dramStrobe <= 1'b0;
            dramSeq <= 1'b0;
            refreshActive <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (dmaStart) begin
                        state <= ST_DMA;
                        kind <= next_kind;
                        wordCnt <= dma_addr_gen_pkg::WORD_FIRST;
                        dramAddr <= {next_ptr, dma_addr_gen_pkg::WORD_FIRST,
                                     dma_addr_gen_pkg::BYTE_LANE_ZERO};
                        dramStrobe <= 1'b1;
                        dramSeq <= 1'b0;
                    end else if (refreshStart) begin
                        state <= ST_REFRESH;
                        dramAddr <= {videoPtr, dma_addr_gen_pkg::WORD_FIRST,
                                     dma_addr_gen_pkg::BYTE_LANE_ZERO};
                        dramStrobe <= 1'b1;
                        dramSeq <= 1'b0;
                        refreshActive <= 1'b1;
                    end
                end
                ST_DMA: begin
                    if (dmaDone) begin
                        state <= ST_IDLE;
                        dramStrobe <= 1'b0;
                        dramSeq <= 1'b0;
                    end else if (memAck) begin
                        wordCnt <= wordCnt + dma_addr_gen_pkg::WORD_STEP;
                        dramAddr <= {
                            dramAddr[dma_addr_gen_pkg::DRAM_ADDR_W-1:4],
                            wordCnt + dma_addr_gen_pkg::WORD_STEP,
                            dma_addr_gen_pkg::BYTE_LANE_ZERO};
                        dramSeq <= 1'b1;
                    end
                end
                ST_REFRESH: begin
                    if (memAck) begin
                        state <= ST_IDLE;
                        dramStrobe <= 1'b0;
                        refreshActive <= 1'b0;
                    end
                end
            endcase
        end
    end

    // per-word acknowledge strobes, low for one cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vc_dma_ack_n <= 1'b1;
            soundDmaAckN <= 1'b1;
        end else begin
            vc_dma_ack_n <= ~(wordTaken
                & (kind != dma_addr_gen_pkg::KIND_SOUND));
            soundDmaAckN <= ~(wordTaken
                & (kind == dma_addr_gen_pkg::KIND_SOUND));
        end
    end

    // ----------------------------------------------------------------
    // flyback initialisation windows
    // ----------------------------------------------------------------
    assign initOk = (state == ST_IDLE) & ~dmaPending & ~refreshReq
        & cpuCycle & cpuMreq & ~cpuSeq & ~regWrite;

    // video init owed from flyback fall until it is carried out
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            videoInitDue <= 1'b0;
        end else if (flybackPrev & ~flyback) begin
            videoInitDue <= 1'b1;
        end else if (initOk) begin
            videoInitDue <= 1'b0;
        end
    end

    // video pointer: frame init, refresh step, circular fetch step
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            videoPtr <= dma_addr_gen_pkg::PTR_RESET;
        end else if (initOk & videoInitDue) begin
            videoPtr <= video_frame_init_pointer;
        end else if ((state == ST_REFRESH) & memAck) begin
            videoPtr <= videoPtr + dma_addr_gen_pkg::PTR_STEP;
        end else if (dmaDone & (kind == dma_addr_gen_pkg::KIND_VIDEO)) begin
            if (videoPtr == video_buffer_end) begin
                videoPtr <= video_buffer_start;
            end else begin
                videoPtr <= videoPtr + dma_addr_gen_pkg::PTR_STEP;
            end
        end
    end

    // cursor pointer: init during flyback, linear fetch step
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cursorPtr <= dma_addr_gen_pkg::PTR_RESET;
        end else if (initOk & flyback) begin
            cursorPtr <= cursor_buffer_init;
        end else if (dmaDone & (kind == dma_addr_gen_pkg::KIND_CURSOR)) begin
            cursorPtr <= cursorPtr + dma_addr_gen_pkg::PTR_STEP;
        end
    end

    // ----------------------------------------------------------------
    // processor bus control
    // ----------------------------------------------------------------
    // i/o cycle is withdrawn at a low i/o clock and resumed after dma
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ioHold <= 1'b0;
        end else if (~ioHold & ioWaiting & dmaPending & ioClkLow
                     & (state == ST_IDLE)) begin
            ioHold <= 1'b1;
        end else if (dmaDone) begin
            ioHold <= 1'b0;
        end
    end

    // bus drivers off for dma or i/o hold, phase-one held while memory is busy
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_bus_drive_en <= 1'b1;
            cpuPhi1Hold <= 1'b0;
            io_cycle_req_n <= 1'b1;
        end else begin
            cpu_bus_drive_en <= ~(dmaStart | ioHold
                | ((state == ST_DMA) & ~dmaDone));
            cpuPhi1Hold <= cpuMreq & (dmaStart | refreshStart
                | ((state != ST_IDLE) & ~(dmaDone
                | ((state == ST_REFRESH) & memAck))));
            io_cycle_req_n <= ~(ioCycleWanted & ~ioHold);
        end
    end

endmodule : video_cursor_sound_dma

// ==== core/dma_addr_gen_pkg.sv ====
// constants and types shared by the dma address generator files
// assumes a 15-bit quadword pointer space (bottom half megabyte of dram)
package dma_addr_gen_pkg;

    // ----------------------------------------------------------------
    // pointer and address layout
    // ----------------------------------------------------------------
    localparam int PTR_W = 15;
    localparam int CPU_ADDR_W = 26;
    localparam int DRAM_ADDR_W = 19;
    localparam logic [PTR_W-1:0] PTR_RESET = 15'h0000;
    localparam logic [PTR_W-1:0] PTR_STEP = 15'h0001;

    // ----------------------------------------------------------------
    // register write decode on the processor address lines
    // ----------------------------------------------------------------
    localparam int MATCH_HI = 25;
    localparam int MATCH_LO = 21;
    localparam logic [4:0] MATCH_CODE = 5'h1B;
    localparam int SEL_HI = 19;
    localparam int SEL_LO = 17;
    localparam int VAL_HI = 16;
    localparam int VAL_LO = 2;
    localparam logic [2:0] SEL_VIDEO_INIT = 3'h0;
    localparam logic [2:0] SEL_VIDEO_START = 3'h1;
    localparam logic [2:0] SEL_VIDEO_END = 3'h2;
    localparam logic [2:0] SEL_CURSOR_INIT = 3'h3;
    localparam logic [2:0] SEL_SOUND_START = 3'h4;
    localparam logic [2:0] SEL_SOUND_END = 3'h5;
    localparam logic [2:0] SEL_SOUND_SWAP = 3'h6;

    // ----------------------------------------------------------------
    // transfer shape and arbitration limits
    // ----------------------------------------------------------------
    localparam logic [1:0] WORD_FIRST = 2'h0;
    localparam logic [1:0] WORD_STEP = 2'h1;
    localparam logic [1:0] WORD_PENULT = 2'h2;
    localparam logic [1:0] WORD_LAST = 2'h3;
    localparam logic [1:0] BYTE_LANE_ZERO = 2'h0;
    localparam logic [1:0] MAX_SEQ = 2'h3;
    localparam logic [4:0] PIN_RESET = 5'h07;

    typedef enum logic [1:0] {KIND_VIDEO, KIND_CURSOR, KIND_SOUND} dma_kind_t;

endpackage : dma_addr_gen_pkg

// ==== core/sync_2ff.sv ====
// two flip-flop synchroniser for a group of asynchronous pins
// assumes each bit is independent; no bus coherency is given
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule : sync_2ff

// ==== core/sound_buffer_ctrl.sv ====
// double-buffered sound pointer with next-buffer valid flag and interrupt
// assumes write strobes and advance are one-cycle pulses on the same clock
`timescale 1ns/1ps
module sound_buffer_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wrNextStart,
    input wire logic wrNextEnd,
    input wire logic wrSwap,
    input wire logic [dma_addr_gen_pkg::PTR_W-1:0] wrValue,
    input wire logic advance,
    output logic [dma_addr_gen_pkg::PTR_W-1:0] soundPtr,
    output logic nextValid,
    output logic sound_irq_n
);
    logic [dma_addr_gen_pkg::PTR_W-1:0] nextStart;
    logic [dma_addr_gen_pkg::PTR_W-1:0] nextEnd;
    logic [dma_addr_gen_pkg::PTR_W-1:0] sound_current_buffer_end;
    logic atEnd;
    logic doSwap;

    // ----------------------------------------------------------------
    // swap decision
    // ----------------------------------------------------------------
    assign atEnd = (soundPtr == sound_current_buffer_end);
    assign doSwap = wrSwap | (advance & atEnd & nextValid);

    // pointer: linear step, swap to next start, or fall back to it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            soundPtr <= dma_addr_gen_pkg::PTR_RESET;
        end else if (wrSwap) begin
            soundPtr <= nextStart;
        end else if (advance) begin
            if (atEnd) begin
                soundPtr <= nextStart;
            end else begin
                soundPtr <= soundPtr + dma_addr_gen_pkg::PTR_STEP;
            end
        end
    end

    // next start register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nextStart <= dma_addr_gen_pkg::PTR_RESET;
        end else if (wrNextStart) begin
            nextStart <= wrValue;
        end
    end

    // end registers exchange on a swap; an end write in the same cycle loads nextEnd instead
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nextEnd <= dma_addr_gen_pkg::PTR_RESET;
            sound_current_buffer_end <= dma_addr_gen_pkg::PTR_RESET;
        end else if (doSwap) begin
            nextEnd <= wrNextEnd ? wrValue : sound_current_buffer_end;
            sound_current_buffer_end <= nextEnd;
        end else if (wrNextEnd) begin
            nextEnd <= wrValue;
        end
    end

    // valid flag and interrupt: a start write wins over a swap
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nextValid <= 1'b0;
            sound_irq_n <= 1'b0;
        end else if (wrNextStart) begin
            nextValid <= 1'b1;
            sound_irq_n <= 1'b1;
        end else if (doSwap) begin
            nextValid <= 1'b0;
            sound_irq_n <= 1'b0;
        end
    end
endmodule : sound_buffer_ctrl

// ==== dv/dma_chk_asserts.sv ====
// checker for the dma address generator, watching its top ports only
// assumes one clock domain and an asynchronous active low reset
`timescale 1ns/1ps
module dma_chk (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [25:0] cpuAddr,
    input wire logic cpuCycle,
    input wire logic cpuMreq,
    input wire logic cpuWrite,
    input wire logic cpuSupervisor,
    input wire logic memAck,
    input wire logic [18:0] dramAddr,
    input wire logic dramStrobe,
    input wire logic dramSeq,
    input wire logic refreshActive,
    input wire logic vc_dma_ack_n,
    input wire logic soundDmaAckN,
    input wire logic sound_irq_n,
    input wire logic cpu_bus_drive_en
);
    logic regWr;
    // register write taken while the arbiter sits idle
    assign regWr = cpuCycle && cpuMreq && cpuWrite && !dramStrobe &&
        cpu_bus_drive_en && cpuAddr[25:21] == 5'h1B;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence wordDone;
        memAck && dramStrobe && !refreshActive;
    endsequence
    sequence supWr(logic [2:0] s);
        regWr && cpuSupervisor && cpuAddr[19:17] == s;
    endsequence
    a_reset_irq_low: assert property (disable iff (1'h0)
        !resetn |-> !sound_irq_n) else $error("irq high in reset");
    a_start_release: assert property (supWr(3'h4) |=> sound_irq_n)
        else $error("irq kept low");
    a_swap_irq_low: assert property (supWr(3'h6) |=> !sound_irq_n)
        else $error("irq left high");
    a_user_ignored: assert property (regWr && !cpuSupervisor &&
        !sound_irq_n |=> !sound_irq_n) else $error("user write acted");
    a_dma_bus_off: assert property (dramStrobe && !refreshActive
        |-> !cpu_bus_drive_en) else $error("bus on in dma");
    a_ack_per_word: assert property (wordDone
        |=> !vc_dma_ack_n || !soundDmaAckN) else $error("no word ack");
    a_first_nonseq: assert property ($rose(dramStrobe)
        |-> !dramSeq && dramAddr[3:0] == 4'h0) else $error("bad first");
    a_word_step: assert property (wordDone |=> !dramStrobe ||
        dramSeq && dramAddr == $past(dramAddr) + 19'h4)
        else $error("bad word step");
endmodule : dma_chk
bind video_cursor_sound_dma dma_chk chk_u (.core_clk, .resetn, .cpuAddr,
    .cpuCycle, .cpuMreq, .cpuWrite, .cpuSupervisor, .memAck, .dramAddr,
    .dramStrobe, .dramSeq, .refreshActive, .vc_dma_ack_n, .soundDmaAckN,
    .sound_irq_n, .cpu_bus_drive_en);

// ==== dv/far_side_model.sv ====
// far side: video/cursor and sound requesters and dram word timing
// assumes dramStrobe is held until the last memAck of a transfer
`timescale 1ns/1ps
module far_side_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic vcGo,
    input wire logic sGo,
    input wire logic slow,
    input wire logic dramStrobe,
    input wire logic vc_dma_ack_n,
    input wire logic soundDmaAckN,
    output logic memAck,
    output logic vc_dma_req_n,
    output logic soundDmaReqN
);
    logic [2:0] waitCnt;
    // requests fall on demand and rise at the first acknowledge
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vc_dma_req_n <= 1'h1;
            soundDmaReqN <= 1'h1;
        end else begin
            vc_dma_req_n <= !vcGo && (vc_dma_req_n || !vc_dma_ack_n);
            soundDmaReqN <= !sGo && (soundDmaReqN || !soundDmaAckN);
        end
    end
    // one memAck pulse per word, prompt or stalled
    always_ff @(posedge core_clk) begin
        waitCnt <= dramStrobe && !memAck ? waitCnt + 3'h1 : 3'h0;
        memAck <= dramStrobe && !memAck && waitCnt >= (slow ? 3'h4 : 3'h0);
    end
endmodule : far_side_model

// ==== dv/tb_video_cursor_sound_dma.sv ====
// self-checking bench for the dma address generator
// assumes the far side model answers dram words and raises requests
`timescale 1ns/1ps
module tb_video_cursor_sound_dma;
    logic core_clk = 1'h0, resetn = 1'h0, cpuCycle = 1'h1, cpuMreq = 1'h1;
    logic cpuSeq = 1'h0, cpuWrite = 1'h0, cpuSupervisor = 1'h1, slow = 1'h0;
    logic soundDmaEnable = 1'h0, refreshReq = 1'h0, ioCycleWanted = 1'h0;
    logic ioWaiting = 1'h0, cursor_select_n = 1'h1, flyback_in = 1'h0;
    logic vcGo = 1'h0, sGo = 1'h0, memAck, vc_dma_req_n, soundDmaReqN;
    logic dramStrobe, dramSeq, refreshActive, vc_dma_ack_n, soundDmaAckN;
    logic sound_irq_n, cpu_bus_drive_en, cpuPhi1Hold, io_cycle_req_n;
    logic [3:0] div = 4'h0;
    logic ioClk;
    logic [25:0] cpuAddr = 26'h0;
    logic [18:0] dramAddr;
    int errors = 0, samples_checked = 0;
    video_cursor_sound_dma dut_u (.core_clk, .resetn, .cpuAddr, .cpuCycle,
        .cpuMreq, .cpuSeq, .cpuWrite, .cpuSupervisor, .soundDmaEnable,
        .refreshReq, .ioCycleWanted, .ioWaiting, .memAck, .vc_dma_req_n,
        .soundDmaReqN, .cursor_select_n, .flyback_in, .ioClk, .dramAddr,
        .dramStrobe, .dramSeq, .refreshActive, .vc_dma_ack_n, .soundDmaAckN,
        .sound_irq_n, .cpu_bus_drive_en, .cpuPhi1Hold, .io_cycle_req_n);
    far_side_model far_u (.core_clk, .resetn, .vcGo, .sGo, .slow,
        .dramStrobe, .vc_dma_ack_n, .soundDmaAckN, .memAck, .vc_dma_req_n,
        .soundDmaReqN);
    // clock and a slow i/o timing clock
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) div <= div + 4'h1;
    assign ioClk = div[3];
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] sel, input logic [14:0] v,
        input logic sup);
        @(posedge core_clk);
        cpuAddr <= {5'h1B, 1'h0, sel, v, 2'h0};
        cpuWrite <= 1'h1;
        cpuSupervisor <= sup;
        @(posedge core_clk);
        cpuWrite <= 1'h0;
        cpuSupervisor <= 1'h1;
        repeat (2) @(posedge core_clk);
    endtask : wr
    // request a transfer if asked, then check its first word address
    task automatic dma(input logic v, s, cur, input logic [18:0] exp);
        if (v || s) begin
            cursor_select_n <= !cur;
            repeat (3) @(posedge core_clk);
            vcGo <= v;
            sGo <= s;
            @(posedge core_clk);
            vcGo <= 1'h0;
            sGo <= 1'h0;
        end
        for (int i = 0; i < 99 && !dramStrobe; i++) @(posedge core_clk);
        @(negedge core_clk);
        chk(dramAddr, exp);
        chk({18'h0, cpuPhi1Hold}, 19'h1);
        for (int i = 0; i < 99 && dramStrobe; i++) @(posedge core_clk);
    endtask : dma
    task automatic rfsh(input logic [18:0] exp);
        refreshReq <= 1'h1;
        for (int i = 0; i < 99 && !refreshActive; i++) @(posedge core_clk);
        refreshReq <= 1'h0;
        @(negedge core_clk);
        chk(dramAddr, exp);
        for (int i = 0; i < 99 && refreshActive; i++) @(posedge core_clk);
    endtask : rfsh
    task automatic complete_run;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // main sequence of register writes and transfers
    initial begin
        repeat (8) @(posedge core_clk);
        chk({18'h0, sound_irq_n}, 19'h0);
        resetn <= 1'h1;
        wr(3'h0, 15'h0010, 1'h1);
        wr(3'h1, 15'h0010, 1'h1);
        wr(3'h2, 15'h0011, 1'h1);
        wr(3'h3, 15'h0040, 1'h1);
        flyback_in <= 1'h1;
        repeat (12) @(posedge core_clk);
        flyback_in <= 1'h0;
        repeat (12) @(posedge core_clk);
        dma(1'h1, 1'h0, 1'h0, 19'h00100);
        dma(1'h1, 1'h0, 1'h0, 19'h00110);
        slow <= 1'h1;
        dma(1'h1, 1'h0, 1'h0, 19'h00100);
        dma(1'h1, 1'h0, 1'h1, 19'h00400);
        dma(1'h1, 1'h0, 1'h1, 19'h00410);
        slow <= 1'h0;
        rfsh(19'h00110);
        rfsh(19'h00120);
        wr(3'h5, 15'h0081, 1'h1);
        wr(3'h4, 15'h0080, 1'h1);
        chk({18'h0, sound_irq_n}, 19'h1);
        wr(3'h6, 15'h0000, 1'h1);
        chk({18'h0, sound_irq_n}, 19'h0);
        wr(3'h4, 15'h0090, 1'h0);
        chk({18'h0, sound_irq_n}, 19'h0);
        soundDmaEnable <= 1'h1;
        dma(1'h1, 1'h1, 1'h0, 19'h00130);
        dma(1'h0, 1'h0, 1'h0, 19'h00800);
        dma(1'h0, 1'h1, 1'h0, 19'h00810);
        dma(1'h0, 1'h1, 1'h0, 19'h00800);
        complete_run();
    end
    // watchdog well beyond the expected run length
    initial begin
        #100000;
        errors++;
        complete_run();
    end
endmodule : tb_video_cursor_sound_dma
